// File: hw/acs_cal_sequencer.sv
// Converter core calibration sequencer: foreground, background, low-power
`default_nettype none
`include "acs_consts.svh"
// Overview of operation
// R1: Foreground calibration runs automatically after power-up
// R2: Conversion stops during foreground calibration
// R3: Outputs show mid-code during foreground calibration
// R4: Selected trigger source starts foreground calibration
// R5: Spare core 2 serves 0/1, 3 serves 4/5
// R6: Calibrate one spare, swap in, repeat continuously
// R7: Controller enables background with specific trigger settings
// R8: Controller programs recommended swap delay values
// R9: Low-power mode sleeps spares until calibration due
// R10: Low-power select picks automatic or manual swapping
// R11: Sleep delay then wake delay before calibration
// R12: Automatic mode swaps at once, then sleeps
// R13: Manual mode: trigger high sleeps, low wakes
// R14: Manual swap needs calibration done and trigger high
// R15: Status select drives spare-finished on status pin
// R16: Foreground offset calibration runs once per foreground
// R17: Background offset calibration runs every background cycle
// R18: Offset enabled before enable: offsets of all cores; the code includes the spares only in background mode
// R19: Controller leaves trim registers alone during offset calibration
// R20: Controller reads trims only after foreground done
// R21: Controller never reads trims under background offset
// R22: Reference mode matches main cores to spare
// R23: Controller stays off register port during calibration
// R24: Core swaps happen only on sample boundaries
module acs_cal_sequencer
  import acs_pkg::*;
#(
  parameter int NGRP = 2,
  parameter int SW = 9,
  parameter int UNIT_W = 8
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire acs_cfg_t CAL_CFG_I,
  input wire logic CAL_TRIGGER_PIN_I,
  input wire logic SAMPLE_STROBE_I,
  input wire logic [5:0][SW-1:0] CORE_DATA_I,
  output logic [2*NGRP-1:0][SW-1:0] CH_DATA_O,
  output logic CONVERT_EN_O,
  output logic [5:0] CORE_POWER_O,
  output acs_cal_req_t CAL_REQ_O,
  input wire logic CAL_DONE_I,
  input wire logic [7:0] OFS_RESULT_I,
  output logic CAL_STATUS_PIN_O,
  output logic FOREGROUND_DONE_O,
  output logic [7:0] SWAP_MUX_DELAY_O,
  input wire logic REG_WE_I,
  input wire logic [14:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O
);

  localparam int CW = 8 + UNIT_W;
  localparam logic [2:0] LAST_CORE =
    (NGRP == 2) ? `ACS_LAST_CORE_QUAD : `ACS_LAST_CORE_DUAL;

  acs_state_t st_ff, nxt_st;
  logic [CW-1:0] cnt_ff;
  logic [2:0] fg_core_ff;
  logic grp_ff;
  logic trig_q_ff;
  logic en_q_ff;
  logic os_first_ff;
  logic foreground_done_flag_ff;
  logic spare_done_ff;
  logic [7:0] src_dly_ff;
  logic [7:0] mux_dly_ff;
  logic [7:0] loc_rd_ff;
  logic rd_mem_ff;
  logic [NGRP-1:0][2:0] spare_w;
  logic [NGRP-1:0] spare_on;
  logic [5:0] pwr;
  logic core_is_spare;

  // Trigger source and operating mode decode
  wire logic trig = CAL_CFG_I.trigger_source_select ?
    CAL_TRIGGER_PIN_I : CAL_CFG_I.software_cal_trigger; // [R4]
  wire logic trig_rise = trig & ~trig_q_ff;
  // A low trigger in manual low-power mode must not drop background mode
  wire logic bg_mode = CAL_CFG_I.cal_enable & CAL_CFG_I.background_cal_enable &
    ~CAL_CFG_I.trigger_source_select & (CAL_CFG_I.software_cal_trigger |
    (CAL_CFG_I.low_power_enable & CAL_CFG_I.low_power_manual_select)); // [R7] [R13]
  wire logic lp_mode = bg_mode & CAL_CFG_I.low_power_enable; // [R9]
  wire logic manual = lp_mode & CAL_CFG_I.low_power_manual_select; // [R10]
  wire logic fg_req = trig_rise & CAL_CFG_I.cal_enable & ~bg_mode; // [R4]
  wire logic fg_busy = (st_ff == ST_FG_CAL) || (st_ff == ST_FG_WAIT);
  wire logic fg_last = (fg_core_ff == LAST_CORE);
  wire acs_state_t bg_entry = lp_mode ? ST_BG_SLEEP : ST_BG_CAL; // [R9]

  // Delay terminals; each delay step is 2**UNIT_W clock cycles
  wire logic sleep_end = cnt_ff >= {CAL_CFG_I.spare_sleep_delay, {UNIT_W{1'b1}}}; // [R11]
  wire logic wake_end = cnt_ff >= {CAL_CFG_I.spare_wake_delay, {UNIT_W{1'b1}}}; // [R11]
  // Source delay holds the swap off a few cycles, then a sample edge fires it
  wire logic swap_go = SAMPLE_STROBE_I && (cnt_ff >= CW'(src_dly_ff)); // [R24]
  wire logic swap_apply = (st_ff == ST_BG_SWAP) && swap_go;

  // Core under calibration and its offset treatment
  wire logic [2:0] cur_core = fg_busy ? fg_core_ff : spare_w[grp_ff];
  wire logic fg_os = CAL_CFG_I.foreground_offset_enable &
    (~core_is_spare | (bg_mode & os_first_ff)); // [R16] [R18]
  wire logic req_offset = fg_busy ? fg_os : CAL_CFG_I.background_offset_enable; // [R17]
  // The reference spare keeps its own offset; only main cores follow it
  wire logic trim_wr_ok = req_offset &
    ~(CAL_CFG_I.spare_offset_reference & core_is_spare); // [R22]
  wire logic cal_wait = (st_ff == ST_FG_WAIT) || (st_ff == ST_BG_WAIT);
  wire logic cal_wr = CAL_DONE_I & cal_wait & trim_wr_ok;

  // Register port decode
  wire logic hit_src = (REG_ADDR_I == `ACS_SRC_DLY_ADDR);
  wire logic hit_mux = (REG_ADDR_I == `ACS_MUX_DLY_ADDR);
  wire logic hit_stat = (REG_ADDR_I == `ACS_STATUS_ADDR);
  wire logic hit_trim = (REG_ADDR_I >= `ACS_TRIM_BASE) && (REG_ADDR_I <= `ACS_TRIM_LAST);
  wire logic [14:0] trim_off = REG_ADDR_I - `ACS_TRIM_BASE;
  wire logic [2:0] trim_idx = trim_off[2:0];
  // Calibration results take the trim port over host writes
  wire logic mem_we = cal_wr | (REG_WE_I & hit_trim);
  wire logic [2:0] mem_waddr = cal_wr ? cur_core : trim_idx;
  wire logic [7:0] mem_wdata = cal_wr ? OFS_RESULT_I : REG_WDATA_I;
  wire logic [7:0] mem_rdata;
  logic [7:0] stat_w;
  logic [7:0] loc_rd_w;

  // Status word and local read mux
  always_comb begin
    stat_w = 8'h00;
    stat_w[`ACS_ST_FOREGROUND_DONE_FLAG] = foreground_done_flag_ff;
    stat_w[`ACS_ST_SPARE_DONE] = spare_done_ff;
    stat_w[`ACS_ST_BUSY] = fg_busy;
    stat_w[`ACS_ST_BG_ACTIVE] = bg_mode;
    loc_rd_w = 8'h00;
    if (hit_src) begin
      loc_rd_w = src_dly_ff;
    end else if (hit_mux) begin
      loc_rd_w = mux_dly_ff;
    end else if (hit_stat) begin
      loc_rd_w = stat_w;
    end
  end

  // Is the selected core currently a spare of any group
  always_comb begin
    core_is_spare = 1'b0;
    for (int g = 0; g < NGRP; g++) begin
      if (spare_w[g] == cur_core) begin
        core_is_spare = 1'b1;
      end
    end
  end

  // Sequencer next state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_FG_CAL: begin
        nxt_st = ST_FG_WAIT;
      end
      ST_FG_WAIT: begin
        if (CAL_DONE_I) begin
          nxt_st = fg_last ? (bg_mode ? bg_entry : ST_IDLE) : ST_FG_CAL;
        end
      end
      ST_IDLE: begin
        if (fg_req) begin
          nxt_st = ST_FG_CAL; // [R4]
        end else if (bg_mode) begin
          nxt_st = bg_entry;
        end
      end
      ST_BG_SLEEP: begin
        if (!bg_mode) begin
          nxt_st = ST_IDLE;
        end else if (!lp_mode) begin
          nxt_st = ST_BG_CAL;
        end else if (manual ? !trig : sleep_end) begin
          nxt_st = ST_BG_WAKE; // [R11] [R13]
        end
      end
      ST_BG_WAKE: begin
        if (!bg_mode) begin
          nxt_st = ST_IDLE;
        end else if (wake_end) begin
          nxt_st = ST_BG_CAL; // [R11] [R13]
        end
      end
      ST_BG_CAL: begin
        nxt_st = ST_BG_WAIT;
      end
      ST_BG_WAIT: begin
        if (CAL_DONE_I) begin
          nxt_st = manual ? ST_BG_HOLD : ST_BG_SWAP; // [R12] [R14]
        end
      end
      ST_BG_HOLD: begin
        if (!bg_mode) begin
          nxt_st = ST_IDLE;
        end else if (trig) begin
          nxt_st = ST_BG_SWAP; // [R14]
        end
      end
      ST_BG_SWAP: begin
        if (swap_go) begin
          nxt_st = lp_mode ? ST_BG_SLEEP : (bg_mode ? ST_BG_CAL : ST_IDLE); // [R6] [R12]
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  // State, delay counter and trigger history
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      st_ff <= ST_FG_CAL; // [R1]
      cnt_ff <= '0;
      trig_q_ff <= 1'b0;
      en_q_ff <= 1'b0;
    end else if (CE_I) begin
      st_ff <= nxt_st;
      // Saturating count restarts on every state change
      cnt_ff <= (nxt_st != st_ff) ? '0 : (&cnt_ff ? cnt_ff : cnt_ff + 1'b1);
      trig_q_ff <= trig;
      en_q_ff <= CAL_CFG_I.cal_enable;
    end
  end

  // Foreground core walk and background group rotation
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      fg_core_ff <= 3'h0;
      grp_ff <= 1'b0;
    end else if (CE_I) begin
      if (st_ff == ST_IDLE) begin
        fg_core_ff <= 3'h0;
      end else if ((st_ff == ST_FG_WAIT) && CAL_DONE_I && !fg_last) begin
        fg_core_ff <= fg_core_ff + 3'h1;
      end
      if (swap_apply && (NGRP == 2)) begin
        grp_ff <= ~grp_ff; // [R6]
      end
    end
  end

  // Offset order latch and completion flags; a set beats a clear
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      os_first_ff <= 1'b0;
      foreground_done_flag_ff <= 1'b0;
      spare_done_ff <= 1'b0;
    end else if (CE_I) begin
      if (CAL_CFG_I.cal_enable && !en_q_ff) begin
        os_first_ff <= CAL_CFG_I.foreground_offset_enable; // [R18]
      end
      if ((st_ff == ST_FG_WAIT) && CAL_DONE_I && fg_last) begin
        foreground_done_flag_ff <= 1'b1;
      end else if (st_ff == ST_FG_CAL) begin
        foreground_done_flag_ff <= 1'b0;
      end
      if ((st_ff == ST_BG_WAIT) && CAL_DONE_I) begin
        spare_done_ff <= 1'b1; // [R15]
      end else if (swap_apply || !bg_mode) begin
        spare_done_ff <= 1'b0;
      end
    end
  end

  // Swap delay registers and read data
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      src_dly_ff <= `ACS_SRC_DLY_RST;
      mux_dly_ff <= `ACS_MUX_DLY_RST;
      loc_rd_ff <= 8'h00;
      rd_mem_ff <= 1'b0;
    end else if (CE_I) begin
      if (REG_WE_I && hit_src) begin
        src_dly_ff <= REG_WDATA_I;
      end
      if (REG_WE_I && hit_mux) begin
        mux_dly_ff <= REG_WDATA_I;
      end
      loc_rd_ff <= loc_rd_w;
      rd_mem_ff <= hit_trim;
    end
  end

  // Per spare group: core map, rotation target and channel data
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    logic [1:0][2:0] map_ff;
    logic [2:0] spare_ff;
    logic tgt_ff;
    logic [1:0][SW-1:0] dat_ff;
    wire logic swap_here = swap_apply && (grp_ff == 1'(g));

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
        map_ff[0] <= (g == 0) ? `ACS_G0_CH0 : `ACS_G1_CH0; // [R5]
        map_ff[1] <= (g == 0) ? `ACS_G0_CH1 : `ACS_G1_CH1;
        spare_ff <= (g == 0) ? `ACS_G0_SPARE : `ACS_G1_SPARE; // [R5]
        tgt_ff <= 1'b0;
        dat_ff <= '0;
      end else if (CE_I) begin
        // Fresh spare takes the target channel; the old core becomes spare
        if (swap_here) begin
          map_ff[tgt_ff] <= spare_ff; // [R6]
          spare_ff <= map_ff[tgt_ff];
          tgt_ff <= ~tgt_ff;
        end
        // Data captured on the same edge uses the old map: clean boundary
        if (SAMPLE_STROBE_I) begin
          for (int i = 0; i < 2; i++) begin
            dat_ff[i] <= fg_busy ? `ACS_MID_CODE : CORE_DATA_I[map_ff[i]]; // [R3] [R24]
          end
        end
      end
    end

    assign spare_w[g] = spare_ff;
    // Spare stays up in foreground and full-power background; in low power only while this group's calibration is due
    assign spare_on[g] = fg_busy | (bg_mode & (~lp_mode |
      ((grp_ff == 1'(g)) & (st_ff != ST_BG_SLEEP)))); // [R9] [R13] [R14]
    assign CH_DATA_O[2*g +: 2] = dat_ff;
  end

  // Core power: active cores always on, idle spares off
  always_comb begin
    pwr = 6'h3F;
    for (int g = 0; g < NGRP; g++) begin
      if (!spare_on[g]) begin
        pwr[spare_w[g]] = 1'b0; // [R9]
      end
    end
  end

  acs_trim_mem #(
    .DW(8),
    .DEPTH(6),
    .AW(3)
  ) u_trim (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(trim_idx),
    .rdata_o(mem_rdata)
  );

  // Outputs
  assign CORE_POWER_O = pwr;
  assign CONVERT_EN_O = ~fg_busy; // [R2]
  assign CAL_REQ_O.start = (st_ff == ST_FG_CAL) || (st_ff == ST_BG_CAL);
  assign CAL_REQ_O.core = cur_core;
  assign CAL_REQ_O.offset = req_offset;
  assign CAL_REQ_O.ref_spare = CAL_CFG_I.spare_offset_reference; // [R22]
  assign CAL_STATUS_PIN_O = CAL_CFG_I.status_select ? spare_done_ff : foreground_done_flag_ff; // [R15]
  assign FOREGROUND_DONE_O = foreground_done_flag_ff;
  assign SWAP_MUX_DELAY_O = mux_dly_ff;
  assign REG_RDATA_O = rd_mem_ff ? mem_rdata : loc_rd_ff;

endmodule // acs_cal_sequencer
`default_nettype wire

// File: hw/acs_consts.svh
// Constants for the converter core calibration sequencer
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// Register offsets on the internal register port
`define ACS_SRC_DLY_ADDR 15'h009A
`define ACS_MUX_DLY_ADDR 15'h009B
`define ACS_STATUS_ADDR 15'h00A0
`define ACS_TRIM_BASE 15'h00A8
`define ACS_TRIM_LAST 15'h00AD

// Register reset values
`define ACS_SRC_DLY_RST 8'h00
`define ACS_MUX_DLY_RST 8'h00
`define ACS_TRIM_RST 8'h00

// Status register bit positions
`define ACS_ST_FOREGROUND_DONE_FLAG 0
`define ACS_ST_SPARE_DONE 1
`define ACS_ST_BUSY 2
`define ACS_ST_BG_ACTIVE 3

// Output code while converting is stopped
`define ACS_MID_CODE 9'h000

// Core map after power-up, per spare group
`define ACS_G0_CH0 3'h0
`define ACS_G0_CH1 3'h1
`define ACS_G0_SPARE 3'h2
`define ACS_G1_CH0 3'h4
`define ACS_G1_CH1 3'h5
`define ACS_G1_SPARE 3'h3

// Cores walked by foreground calibration
`define ACS_LAST_CORE_QUAD 3'h5
`define ACS_LAST_CORE_DUAL 3'h2

`endif

// File: hw/acs_pkg.sv
// Types shared by the calibration sequencer files
`default_nettype none
package acs_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_FG_CAL, ST_FG_WAIT, ST_IDLE, ST_BG_SLEEP, ST_BG_WAKE,
    ST_BG_CAL, ST_BG_WAIT, ST_BG_HOLD, ST_BG_SWAP
  } acs_state_t;

  // Calibration configuration from the system controller
  typedef struct packed {
    logic cal_enable;
    logic software_cal_trigger;
    logic trigger_source_select;
    logic background_cal_enable;
    logic low_power_enable;
    logic low_power_manual_select;
    logic status_select;
    logic foreground_offset_enable;
    logic background_offset_enable;
    logic spare_offset_reference;
    logic [7:0] spare_sleep_delay;
    logic [7:0] spare_wake_delay;
  } acs_cfg_t;

  // Request to the analog calibration engine
  typedef struct packed {
    logic start;
    logic [2:0] core;
    logic offset;
    logic ref_spare;
  } acs_cal_req_t;

endpackage
`default_nettype wire

// File: hw/acs_trim_mem.sv
// Per-core offset trim storage with registered read
`default_nettype none
`include "acs_consts.svh"
module acs_trim_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 6,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DEPTH-1:0][DW-1:0] mem_ff;
  logic [DW-1:0] rdata_ff;

  // Out-of-range addresses read zero and drop writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ff <= {DEPTH{DW'(`ACS_TRIM_RST)}};
      rdata_ff <= '0;
    end else if (ce_i) begin
      if (we_i && (32'(waddr_i) < DEPTH)) begin
        mem_ff[waddr_i] <= wdata_i;
      end
      rdata_ff <= (32'(raddr_i) < DEPTH) ? mem_ff[raddr_i] : '0;
    end
  end

  assign rdata_o = rdata_ff;

endmodule // acs_trim_mem
`default_nettype wire

// File: verif/acs_cal_engine_model.sv
// Behavioural analog calibration engine facing the sequencer
`default_nettype none
module acs_cal_engine_model
  import acs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire acs_cal_req_t req_i,
  output logic done_o,
  output logic [7:0] result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Countdown per request; result only meaningful with done, scrambled otherwise
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      result_o <= 8'h00;
    end else begin
      done_o <= (cnt == 1);
      result_o <= (cnt == 1) ? 8'h40 + 8'(req_i.core) : ~result_o;
      if (req_i.start) begin
        cnt <= slow_i ? 12 : 2;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // acs_cal_engine_model
`default_nettype wire

// File: verif/acs_cal_sequencer_checker.sv
// Port-level assertions for the calibration sequencer
`default_nettype none
`include "acs_consts.svh"
module acs_cal_sequencer_checker
  import acs_pkg::*;
#(
  parameter int NGRP = 2,
  parameter int SW = 9,
  parameter int UNIT_W = 8
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire acs_cfg_t CAL_CFG_I,
  input wire logic SAMPLE_STROBE_I,
  input wire logic [2*NGRP-1:0][SW-1:0] CH_DATA_O,
  input wire logic CONVERT_EN_O,
  input wire acs_cal_req_t CAL_REQ_O,
  input wire logic CAL_DONE_I,
  input wire logic CAL_STATUS_PIN_O,
  input wire logic FOREGROUND_DONE_O,
  input wire logic [7:0] SWAP_MUX_DELAY_O,
  input wire logic REG_WE_I,
  input wire logic [14:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  localparam logic [2:0] LAST = (NGRP == 2) ? `ACS_LAST_CORE_QUAD : `ACS_LAST_CORE_DUAL;
  wire bg_mode = CAL_CFG_I.cal_enable && CAL_CFG_I.background_cal_enable &&
    !CAL_CFG_I.trigger_source_select && CAL_CFG_I.software_cal_trigger;
  // Register write followed by a read of the same place
  sequence s_src_write;
    REG_WE_I && CE_I && REG_ADDR_I == `ACS_SRC_DLY_ADDR;
  endsequence
  sequence s_src_read;
    !REG_WE_I && CE_I && REG_ADDR_I == `ACS_SRC_DLY_ADDR;
  endsequence
  a_mid_code_out: assert property (!CONVERT_EN_O && SAMPLE_STROBE_I && CE_I |=>
    CH_DATA_O == '0) else $error("channel data not mid-code while stopped");
  a_stop_until_done: assert property (!FOREGROUND_DONE_O |-> !CONVERT_EN_O)
    else $error("converting before foreground done");
  a_resume_after_fg: assert property ($rose(FOREGROUND_DONE_O) |-> ##[0:1] CONVERT_EN_O)
    else $error("conversion did not resume");
  a_start_one_cycle: assert property (CAL_REQ_O.start && CE_I |=> !CAL_REQ_O.start)
    else $error("start longer than one cycle");
  a_walk_next_core: assert property (CAL_DONE_I && CE_I && !CONVERT_EN_O &&
    CAL_REQ_O.core < LAST |=> CAL_REQ_O.start && CAL_REQ_O.core == $past(CAL_REQ_O.core) + 3'h1)
    else $error("foreground walk skipped a core");
  a_status_fg_flag: assert property (!CAL_CFG_I.status_select &&
    !$past(CAL_CFG_I.status_select) |-> CAL_STATUS_PIN_O == FOREGROUND_DONE_O)
    else $error("status pin source wrong");
  a_src_readback: assert property (s_src_write ##1 s_src_read |=>
    REG_RDATA_O == $past(REG_WDATA_I, 2)) else $error("source delay readback wrong");
  a_mux_delay_out: assert property (REG_WE_I && CE_I && REG_ADDR_I == `ACS_MUX_DLY_ADDR
    |=> SWAP_MUX_DELAY_O == $past(REG_WDATA_I)) else $error("mux delay output wrong");
  a_unmapped_zero: assert property (CE_I && REG_ADDR_I == 15'h0010 |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_bg_no_gap: assert property (CONVERT_EN_O && bg_mode && $stable(CAL_CFG_I)
    |=> CONVERT_EN_O) else $error("background mode stopped conversion");
endmodule // acs_cal_sequencer_checker
bind acs_cal_sequencer acs_cal_sequencer_checker #(.NGRP(NGRP), .SW(SW), .UNIT_W(UNIT_W))
  i_acs_cal_sequencer_checker (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I),
  .CAL_CFG_I(CAL_CFG_I), .SAMPLE_STROBE_I(SAMPLE_STROBE_I), .CH_DATA_O(CH_DATA_O),
  .CONVERT_EN_O(CONVERT_EN_O), .CAL_REQ_O(CAL_REQ_O), .CAL_DONE_I(CAL_DONE_I),
  .CAL_STATUS_PIN_O(CAL_STATUS_PIN_O), .FOREGROUND_DONE_O(FOREGROUND_DONE_O),
  .SWAP_MUX_DELAY_O(SWAP_MUX_DELAY_O), .REG_WE_I(REG_WE_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O));
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the calibration sequencer
`default_nettype none
`include "acs_consts.svh"
module testbench
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, we = 0, pin = 0, strobe = 0, done, slow = 0, conv, fgd, stat;
  logic [14:0] addr = '0;
  logic [7:0] wdata = '0, rdata, res, muxd;
  logic [5:0][8:0] core_data;
  logic [3:0][8:0] ch;
  logic [5:0] pwr;
  acs_cfg_t cfg = '0;
  acs_cal_req_t req;
  int n_errors = 0, checked = 0, cyc = 0;
  acs_cal_sequencer #(.NGRP(2), .SW(9), .UNIT_W(2)) i_acs_cal_sequencer (.CLOCK_I(clk),
    .RST_I(rst), .CE_I(1'b1), .CAL_CFG_I(cfg), .CAL_TRIGGER_PIN_I(pin),
    .SAMPLE_STROBE_I(strobe), .CORE_DATA_I(core_data), .CH_DATA_O(ch), .CONVERT_EN_O(conv),
    .CORE_POWER_O(pwr), .CAL_REQ_O(req), .CAL_DONE_I(done), .OFS_RESULT_I(res),
    .CAL_STATUS_PIN_O(stat), .FOREGROUND_DONE_O(fgd), .SWAP_MUX_DELAY_O(muxd),
    .REG_WE_I(we), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata));
  acs_cal_engine_model i_acs_cal_engine_model (.clk_i(clk), .rst_i(rst), .slow_i(slow),
    .req_i(req), .done_o(done), .result_o(res));
  // Clock and a sample boundary every fourth cycle
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    strobe <= (cyc % 4 == 0);
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Bounded wait on a condition sampled after each edge
  task automatic wait_on(input string name, input int lim, ref logic cond);
    int i;
    for (i = 0; i < lim && cond !== 1'b1; i++) @(posedge clk) #1;
    if (cond !== 1'b1) begin
      chk(name, 16'h0, 16'h1);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [14:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(posedge clk) #1;
    chk(name, 16'(rdata), 16'(exp));
  endtask
  logic w;
  // Bounded wait until the given number of cores is powered
  task automatic wait_pwr(input string name, input int n_on);
    w = 1'b0;
    for (int i = 0; i < 3000 && w !== 1'b1; i++) @(posedge clk) #1 w = ($countones(pwr) == n_on);
    chk(name, 16'(w), 16'h1);
    if (w !== 1'b1) give_verdict();
  endtask
  task automatic t_power_up;
    #1 chk("conv_en", 16'(conv), 16'h0);
    wait_on("foreground_done_flag", 3000, fgd);
    chk("conv_after", 16'(conv), 16'h1);
    chk("stat_pin", 16'(stat), 16'h1);
    // Register port only once the power-up calibration is over
    rd_chk("src_rst", `ACS_SRC_DLY_ADDR, `ACS_SRC_DLY_RST);
    rd_chk("status", `ACS_STATUS_ADDR, 8'h01);
  endtask
  task automatic t_regs;
    wr(`ACS_SRC_DLY_ADDR, 8'h1F);
    wr(`ACS_MUX_DLY_ADDR, 8'h1E);
    rd_chk("src_dly", `ACS_SRC_DLY_ADDR, 8'h1F);
    chk("mux_out", 16'(muxd), 16'h001E);
    rd_chk("unmapped", 15'h0010, 8'h00);
  endtask
  task automatic t_soft_offset;
    logic [7:0] e;
    @(posedge clk);
    cfg.cal_enable <= 1'b0;
    cfg.foreground_offset_enable <= 1'b1; // Trims left to the engine from here on
    @(posedge clk);
    cfg.cal_enable <= 1'b1;
    slow <= 1'b1;
    @(posedge clk);
    cfg.software_cal_trigger <= 1'b1;
    @(posedge clk);
    @(posedge clk) #1;
    chk("soft_stop", 16'(conv), 16'h0);
    wait_on("soft_done", 3000, fgd);
    for (int k = 0; k < 6; k++) begin
      // Spares 2 and 3 sit out a foreground run without background mode
      e = (k == 2 || k == 3) ? `ACS_TRIM_RST : 8'(8'h40 + k);
      rd_chk("trim", 15'(`ACS_TRIM_BASE + k), e);
    end
  endtask
  task automatic t_pin;
    @(posedge clk);
    cfg.trigger_source_select <= 1'b1;
    slow <= 1'b0;
    @(posedge clk);
    pin <= 1'b1;
    @(posedge clk);
    @(posedge clk) #1;
    chk("pin_stop", 16'(conv), 16'h0);
    wait_on("pin_done", 3000, fgd);
    @(posedge clk);
    pin <= 1'b0;
  endtask
  task automatic t_background;
    @(posedge clk);
    cfg.background_offset_enable <= 1'b1; // No trim reads from here on
    cfg.trigger_source_select <= 1'b0;
    cfg.background_cal_enable <= 1'b1;
    cfg.status_select <= 1'b1;
    rd_chk("bg_active", `ACS_STATUS_ADDR, 8'h09);
    wait_on("spare_done", 3000, stat);
    chk("bg_offset", 16'(req.offset), 16'h1);
    chk("bg_conv", 16'(conv), 16'h1);
    w = 1'b0;
    for (int i = 0; i < 3000 && w !== 1'b1; i++) @(posedge clk) #1
      w = (ch[0] === core_data[2] || ch[1] === core_data[2]);
    chk("spare_in", 16'(w), 16'h1);
    if (w !== 1'b1) give_verdict();
  endtask
  // Both spares asleep leaves four cores powered; a waking spare makes five
  task automatic t_low_power;
    int n;
    @(posedge clk);
    cfg.low_power_enable <= 1'b1;
    cfg.spare_sleep_delay <= 8'h01;
    cfg.spare_wake_delay <= 8'h01;
    wait_pwr("spare_off", 4);
    // Sleep lasts two delay steps of four cycles each
    n = 1;
    w = 1'b0;
    for (int i = 0; i < 3000 && w !== 1'b1; i++) begin
      @(posedge clk) #1;
      n += int'($countones(pwr) == 4);
      w = ($countones(pwr) == 5);
    end
    chk("spare_wake", 16'(w), 16'h1);
    if (w !== 1'b1) give_verdict();
    chk("sleep_len", 16'(n), 16'h0008);
  endtask
  // Manual low-power: trigger high sleeps, low wakes, high again swaps
  task automatic t_manual;
    @(posedge clk);
    cfg.low_power_manual_select <= 1'b1;
    wait_pwr("man_asleep", 4);
    repeat (100) @(posedge clk);
    #1 chk("man_held", 16'($countones(pwr)), 16'h0004);
    @(posedge clk);
    cfg.software_cal_trigger <= 1'b0;
    wait_on("man_cal", 3000, stat);
    repeat (100) @(posedge clk);
    #1 chk("man_hold", 16'($countones(pwr)), 16'h0005);
    chk("man_stat", 16'(stat), 16'h1);
    @(posedge clk);
    cfg.software_cal_trigger <= 1'b1;
    wait_pwr("man_swap", 4);
    chk("man_clear", 16'(stat), 16'h0);
  endtask
  initial begin
    for (int k = 0; k < 6; k++) core_data[k] = 9'(16 * k + 3);
    cfg.cal_enable = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_power_up();
    t_regs();
    t_soft_offset();
    t_pin();
    t_background();
    t_low_power();
    t_manual();
    give_verdict();
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    chk("timeout", 16'h0, 16'h1);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
